/* logic/bank_close_ctrl.sv */
// Controller end: issues one user command when all bank spacing is met.
// Assumes the device end follows the same timing constants.
`include "bank_close_defs.svh"
module bank_close_ctrl
  import bank_close_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Sync reset, active high
  bank_close_if.ctrl link, // Command link
  input wire logic i_req_valid, // Command request
  input bank_close_pkg::cmd_t i_req_cmd, // Requested command
  input wire logic [2:0] i_req_bank, // Target bank
  input wire logic [13:0] i_req_addr, // Row/column, bit 10 auto/all
  input wire logic [2:0] i_al, // Additive latency
  input wire logic [2:0] i_cl, // CAS latency
  input wire logic i_bl8, // Burst length 8
  output logic o_req_ready // High when a request would be taken this cycle
);
  import bank_close_pkg::*;
  logic [`CNT_W-1:0] pre_ok_q [`NUM_BANKS];
  logic [`CNT_W-1:0] act_ok_q [`NUM_BANKS];
  logic [`NUM_BANKS-1:0] open_q;
  logic cs_n_q, ras_n_q, cas_n_q, we_n_q;
  logic [2:0] ba_q;
  logic [13:0] addr_q;
  wire [`CNT_W-1:0] bl_half = i_bl8 ? `CNT_W'(4) : `CNT_W'(2);
  wire [`CNT_W-1:0] rtp_m = (`RTP_CYC > 2) ? `CNT_W'(`RTP_CYC) : `CNT_W'(2);
  wire [`CNT_W-1:0] rd_pre = `CNT_W'(i_al) + bl_half + rtp_m - `CNT_W'(2);
  wire [`CNT_W-1:0] wl = `CNT_W'(i_al) + `CNT_W'(i_cl) - `CNT_W'(1);
  wire [`CNT_W-1:0] wr_pre = wl + bl_half + `CNT_W'(`WR_CYC);
  wire [`CNT_W-1:0] rd_ap_act = rd_pre + `CNT_W'(`RP_CYC + 2);
  wire [`CNT_W-1:0] wr_ap_act = wr_pre + `CNT_W'(`RP_CYC);
  wire auto = i_req_addr[`ALL_BANKS_BIT];
  wire [`NUM_BANKS-1:0] pre_tgt = auto ? {`NUM_BANKS{1'b1}} : (`NUM_BANKS'(1) << i_req_bank);
  logic all_pre_ok;
  always_comb begin
    all_pre_ok = 1'b1;
    for (int i = 0; i < `NUM_BANKS; i++)
      if (pre_tgt[i] && pre_ok_q[i] != '0) all_pre_ok = 1'b0;
  end
  wire bank_open = open_q[i_req_bank];
  wire bank_free = act_ok_q[i_req_bank] == '0;
  logic ok;
  always_comb begin
    unique case (i_req_cmd)
      CMD_NOP: ok = 1'b1;
      CMD_ACT: ok = !bank_open && bank_free;
      CMD_RD, CMD_WR: ok = bank_open;
      CMD_PRE: ok = all_pre_ok;
      default: ok = 1'b0;
    endcase
  end
  assign o_req_ready = ok;
  wire take = i_req_valid && ok;
  assign link.cs_n = cs_n_q;
  assign link.ras_n = ras_n_q;
  assign link.cas_n = cas_n_q;
  assign link.we_n = we_n_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'hf;
      ba_q <= 3'h0;
      addr_q <= 14'h0000;
    end else begin
      cs_n_q <= !(take && i_req_cmd != CMD_NOP);
      ras_n_q <= !(take && (i_req_cmd == CMD_ACT || i_req_cmd == CMD_PRE));
      cas_n_q <= !(take && (i_req_cmd == CMD_RD || i_req_cmd == CMD_WR));
      we_n_q <= !(take && (i_req_cmd == CMD_WR || i_req_cmd == CMD_PRE));
      ba_q <= i_req_bank;
      addr_q <= i_req_addr;
    end
  end
  genvar b;
  for (b = 0; b < `NUM_BANKS; b++) begin : g_bank
    wire me = i_req_bank == 3'(b);
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        open_q[b] <= 1'b0;
        pre_ok_q[b] <= '0;
        act_ok_q[b] <= '0;
      end else if (take && i_req_cmd == CMD_ACT && me) begin
        open_q[b] <= 1'b1;
        pre_ok_q[b] <= `CNT_W'(`RAS_CYC);
        act_ok_q[b] <= `CNT_W'(`RC_CYC);
      end else if (take && (i_req_cmd == CMD_RD || i_req_cmd == CMD_WR) && me) begin
        open_q[b] <= !auto;
        if (i_req_cmd == CMD_RD) begin
          pre_ok_q[b] <= (rd_pre > pre_ok_q[b]) ? rd_pre : pre_ok_q[b];
          if (auto) act_ok_q[b] <= (rd_ap_act > act_ok_q[b]) ? rd_ap_act : act_ok_q[b];
        end else begin
          pre_ok_q[b] <= (wr_pre > pre_ok_q[b]) ? wr_pre : pre_ok_q[b];
          if (auto) act_ok_q[b] <= (wr_ap_act > act_ok_q[b]) ? wr_ap_act : act_ok_q[b];
        end
      end else if (take && i_req_cmd == CMD_PRE && pre_tgt[b]) begin
        open_q[b] <= 1'b0;
        act_ok_q[b] <= (`CNT_W'(`RP_CYC) > act_ok_q[b]) ? `CNT_W'(`RP_CYC) : act_ok_q[b];
      end else begin
        if (pre_ok_q[b] != '0) pre_ok_q[b] <= pre_ok_q[b] - 1'b1;
        if (act_ok_q[b] != '0) act_ok_q[b] <= act_ok_q[b] - 1'b1;
      end
    end
  end
endmodule

/* logic/bank_close_defs.svh */
// Timing constants for the bank close timing model and its command issuer.
// Assumes a 50 MHz system clock; analog times are in ns and rounded to cycles here.
`ifndef BANK_CLOSE_DEFS_SVH
`define BANK_CLOSE_DEFS_SVH
`define CLK_PERIOD_NS 20
`define NUM_BANKS 8
`define T_RTP_NS 8
`define T_RP_NS 15
`define T_RAS_NS 45
`define T_RC_NS 60
`define T_WR_NS 15
// Least times round up
`define RTP_CYC ((`T_RTP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAS_CYC ((`T_RAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RC_CYC ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYC ((`T_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ALL_BANKS_BIT 10
`define CNT_W 6
`define AL_DEFAULT 3'h0
`define CL_DEFAULT 3'h3
`endif

/* logic/bank_close_dev.sv */
// Device end: decodes link commands and runs eight bank close timers.
// Assumes the controller end keeps the far-side spacing.
`include "bank_close_defs.svh"
module bank_close_dev
  import bank_close_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Sync reset, active high
  bank_close_if.dev link, // Command link
  input wire logic [2:0] i_al, // Additive latency
  input wire logic [2:0] i_cl, // CAS latency
  input wire logic i_bl8, // Burst length 8
  output logic [`NUM_BANKS-1:0] o_bank_open, // Bank open flags
  output logic [`NUM_BANKS-1:0] o_bank_closing // Bank closing flags
);
  import bank_close_pkg::*;
  wire sel = !link.cs_n;
  wire is_act = sel && !link.ras_n && link.cas_n && link.we_n;
  wire is_rd = sel && link.ras_n && !link.cas_n && link.we_n;
  wire is_wr = sel && link.ras_n && !link.cas_n && !link.we_n;
  wire is_pre = sel && !link.ras_n && link.cas_n && !link.we_n;
  wire all_b = link.addr[`ALL_BANKS_BIT];
  genvar b;
  for (b = 0; b < `NUM_BANKS; b++) begin : g_bank
    wire hit = link.ba == 3'(b);
    bank_close_pkg::bank_state_t st;
    bank_timer u_bank (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_act(is_act && hit),
      .i_rd(is_rd && hit),
      .i_wr(is_wr && hit),
      .i_auto(all_b),
      .i_pre(is_pre && (hit || all_b)),
      .i_al(i_al),
      .i_cl(i_cl),
      .i_bl8(i_bl8),
      .o_state(st),
      .o_close_start()
    );
    assign o_bank_open[b] = st == BANK_OPEN;
    assign o_bank_closing[b] = st == BANK_CLOSING;
  end
endmodule

/* logic/bank_close_if.sv */
// Command link between memory controller end and device end.
// Assumes one shared clock; commands are taken on the rising edge.
interface bank_close_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev (input cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

/* logic/bank_close_pkg.sv */
// Types for the link ends: cmd_t at the controller, bank_state_t at the device.
// Assumes the defs header is on the include path.
package bank_close_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} cmd_t;
  typedef enum logic [1:0] {BANK_IDLE, BANK_OPEN, BANK_CLOSING} bank_state_t;
endpackage

/* logic/bank_timer.sv */
// One bank's open / closing / idle tracker with its own close timing.
// Assumes commands arrive already decoded and aimed at this bank.
`include "bank_close_defs.svh"
module bank_timer
  import bank_close_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_act, // Activate to this bank
  input wire logic i_rd, // Read to this bank
  input wire logic i_wr, // Write to this bank
  input wire logic i_auto, // Auto close flag with rd/wr
  input wire logic i_pre, // Explicit close to this bank
  input wire logic [2:0] i_al, // Additive latency
  input wire logic [2:0] i_cl, // CAS latency
  input wire logic i_bl8, // Burst length 8
  output bank_close_pkg::bank_state_t o_state, // Bank state
  output logic o_close_start // Close began, auto or explicit
);
  import bank_close_pkg::*;
  bank_state_t state_q;
  logic [`CNT_W-1:0] ras_q, rp_q, wait_q;
  logic ap_q;
  // Read: AL + BL/2, not before AL(+2) + RTP_CYC; write: WL + BL/2 + WR
  wire [`CNT_W-1:0] bl_half = i_bl8 ? `CNT_W'(4) : `CNT_W'(2);
  wire [`CNT_W-1:0] rd_edge = `CNT_W'(i_al) + bl_half;
  wire [`CNT_W-1:0] rtp_edge = `CNT_W'(i_al) + (i_bl8 ? `CNT_W'(2) : `CNT_W'(0)) + `CNT_W'(`RTP_CYC);
  wire [`CNT_W-1:0] rd_wait = (rtp_edge > rd_edge) ? rtp_edge : rd_edge;
  wire [`CNT_W-1:0] wr_wait = `CNT_W'(i_al) + `CNT_W'(i_cl) - `CNT_W'(1) + bl_half + `CNT_W'(`WR_CYC);
  wire start_now = ap_q && wait_q == '0 && ras_q == '0;
  wire close_now = (state_q == BANK_OPEN) && (start_now || i_pre);
  assign o_state = state_q;
  assign o_close_start = close_now;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= BANK_IDLE;
      ras_q <= '0;
      rp_q <= '0;
      wait_q <= '0;
      ap_q <= 1'b0;
    end else begin
      if (ras_q != '0) ras_q <= ras_q - 1'b1;
      if (wait_q != '0) wait_q <= wait_q - 1'b1;
      if (rp_q != '0) rp_q <= rp_q - 1'b1;
      unique case (state_q)
        BANK_IDLE: if (i_act) begin
          state_q <= BANK_OPEN;
          ras_q <= `CNT_W'(`RAS_CYC - 1);
        end
        BANK_OPEN: if (close_now) begin
          state_q <= BANK_CLOSING;
          rp_q <= `CNT_W'(`RP_CYC - 1);
          ap_q <= 1'b0;
        end else if (i_rd || i_wr) begin
          ap_q <= i_auto;
          wait_q <= (i_rd ? rd_wait : wr_wait) - `CNT_W'(1);
        end
        BANK_CLOSING: if (rp_q == '0) state_q <= BANK_IDLE;
      endcase
    end
  end
endmodule

/* tb/bank_close_properties.sv */
// Concurrent checks on the command link and the device bank flags.
// Assumes one clock, a synchronous active-high reset and the shared timing constants.
module bank_close_properties (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Sync reset
  input wire logic cs_n, // Link select
  input wire logic ras_n, // Link row strobe
  input wire logic cas_n, // Link column strobe
  input wire logic we_n, // Link write enable
  input wire logic [2:0] ba, // Link bank
  input wire logic [13:0] addr, // Link address
  input wire logic [7:0] o_bank_open, // Open flags
  input wire logic [7:0] o_bank_closing // Closing flags
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  logic [2:0] ap_bank_q;
  wire is_act = !cs_n && !ras_n && cas_n && we_n;
  wire is_rw = !cs_n && ras_n && !cas_n;
  wire is_pre = !cs_n && !ras_n && cas_n && !we_n;
  wire rw_auto = is_rw && addr[10];
  // Remembers the bank of the latest column access for the auto close checks
  always_ff @(posedge i_sys_clk) begin
    if (is_rw) begin
      ap_bank_q <= ba;
    end
  end
  act_opens_a: assert property (is_act |=> o_bank_open[$past(ba)])
    else $error("activate did not open bank");
  pre_one_a: assert property (is_pre && !addr[10] |=> !o_bank_open[$past(ba)])
    else $error("single close left bank open");
  pre_all_a: assert property (is_pre && addr[10] |=> o_bank_open == 8'h00)
    else $error("close all left a bank open");
  plain_rw_keeps_a: assert property (is_rw && !addr[10] |=> o_bank_open[$past(ba)])
    else $error("plain access closed bank");
  auto_holds_a: assert property (rw_auto |=> o_bank_open[ap_bank_q] [*2])
    else $error("auto close started too early");
  auto_closes_a: assert property (rw_auto |=> ##[1:20] !o_bank_open[ap_bank_q])
    else $error("auto close never started");
  closing_ends_a: assert property (o_bank_closing != 8'h00 |-> ##[1:4] o_bank_closing == 8'h00)
    else $error("closing state did not end");
  flags_apart_a: assert property ((o_bank_open & o_bank_closing) == 8'h00)
    else $error("bank open and closing at once");
  act_needs_idle_a: assert property (is_act |-> !o_bank_open[ba] && !o_bank_closing[ba])
    else $error("activate to busy bank");
  // Only a close that reaches the activated bank counts; other banks may close freely
  ras_before_pre_a: assert property (is_act |=> !(is_pre && (addr[10] || ba == $past(ba)))
    ##1 !(is_pre && (addr[10] || ba == $past(ba, 2))))
    else $error("close too soon after activate");
  cover property (rw_auto && we_n);
  cover property (rw_auto && !we_n);
  cover property (is_pre && addr[10]);
endmodule

/* tb/tb_dram_bank_precharge_timing.sv */
// Bench: controller end drives the device end over the link; spacing is timed on the wire.
// Assumes the design files and the defs header are compiled first.
`include "bank_close_defs.svh"
module tb_dram_bank_precharge_timing;
  timeunit 1ns;
  timeprecision 1ns;
  import bank_close_pkg::*;
  logic [2:0] cl = 3'h3;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req_valid = 1'b0;
  cmd_t req_cmd = CMD_NOP;
  logic [2:0] req_bank = 3'h0;
  logic [13:0] req_addr = 14'h0000;
  logic [2:0] al = 3'h0;
  logic bl8 = 1'b0;
  logic req_ready;
  logic [7:0] bank_open;
  logic [7:0] bank_closing;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int rw_at [8] = '{default: 0};
  int act_at [8] = '{default: 0};
  logic wr_last [8] = '{default: 1'b0};
  logic ap_last [8] = '{default: 1'b0};
  int pre_at [8] = '{default: 0};
  bank_close_if link();
  bank_close_ctrl bank_close_ctrl_i (.i_sys_clk, .i_rst, .link, .i_req_valid(req_valid), .i_req_cmd(req_cmd),
    .i_req_bank(req_bank), .i_req_addr(req_addr), .i_al(al), .i_cl(cl), .i_bl8(bl8), .o_req_ready(req_ready));
  bank_close_dev bank_close_dev_i (.i_sys_clk, .i_rst, .link, .i_al(al), .i_cl(cl), .i_bl8(bl8),
    .o_bank_open(bank_open), .o_bank_closing(bank_closing));
  bank_close_properties bank_close_properties_i (.i_sys_clk, .i_rst, .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .o_bank_open(bank_open),
    .o_bank_closing(bank_closing));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic int gap_pre(input logic w);
    return w ? al + cl - 1 + (bl8 ? 4 : 2) + `WR_CYC : al + (bl8 ? 4 : 2) + ((`RTP_CYC > 2) ? `RTP_CYC : 2) - 2;
  endfunction
  function automatic int gap_act(input logic w);
    return w ? gap_pre(1'b1) + `RP_CYC : al + (bl8 ? 2 : 0) + `RTP_CYC + `RP_CYC;
  endfunction
  // Link is sampled mid-cycle, away from the edge where the controller flops change it
  always @(negedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (!link.cs_n && link.ras_n && !link.cas_n) begin
      rw_at[link.ba] <= cyc;
      wr_last[link.ba] <= !link.we_n;
      ap_last[link.ba] <= link.addr[10];
    end
    // A close to all banks must respect every bank's own access spacing
    if (!link.cs_n && !link.ras_n && link.cas_n && !link.we_n) begin
      for (int i = 0; i < 8; i++) begin
        if (link.addr[10] || link.ba == 3'(i)) begin
          check(32'(cyc - rw_at[i] >= gap_pre(wr_last[i])), 32'h1);
          pre_at[i] <= cyc;
        end
      end
    end
    if (!link.cs_n && !link.ras_n && link.cas_n && link.we_n) begin
      check(32'(cyc - act_at[link.ba] >= `RC_CYC), 32'h1);
      check(32'(cyc - pre_at[link.ba] >= `RP_CYC), 32'h1);
      if (ap_last[link.ba])
        check(32'(cyc - rw_at[link.ba] >= gap_act(wr_last[link.ba])), 32'h1);
      act_at[link.ba] <= cyc;
      ap_last[link.ba] <= 1'b0;
    end
  end
  // Request is held from a falling edge until a rising edge that finds ready high
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [13:0] a);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge i_sys_clk);
      #1;
      n++;
    end
    if (n == 50)
      check(32'h0, 32'h1);
    @(posedge i_sys_clk);
  endtask
  task automatic idle(input int k);
    @(negedge i_sys_clk);
    req_valid = 1'b0;
    repeat (k) @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    for (int m = 0; m < 4; m++) begin
      bl8 = m[0];
      al = m[1] ? 3'h2 : 3'h0;
      // CAS latency moves the write recovery point, so it is varied too
      cl = (m[0] ^ m[1]) ? 3'h4 : 3'h3;
      issue(CMD_ACT, 3'h2, 14'h0123);
      idle(2);
      check(32'(bank_open), 32'h04);
      issue(CMD_NOP, 3'h2, 14'h0400);
      idle(2);
      check(32'(bank_open), 32'h04);
      issue(CMD_RD, 3'h2, 14'h0010);
      idle(3);
      check(32'(bank_open), 32'h04);
      issue(CMD_RD, 3'h2, 14'h0410);
      idle(20);
      check(32'(bank_open), 32'h00);
      issue(CMD_ACT, 3'h2, 14'h0200);
      issue(CMD_WR, 3'h2, 14'h0400);
      idle(2);
      check(32'(bank_open), 32'h04);
      idle(20);
      check(32'(bank_open), 32'h00);
      issue(CMD_ACT, 3'h0, 14'h0001);
      issue(CMD_ACT, 3'h5, 14'h0002);
      issue(CMD_ACT, 3'h7, 14'h0003);
      issue(CMD_WR, 3'h5, 14'h0008);
      issue(CMD_PRE, 3'h5, 14'h0000);
      idle(1);
      check(32'(bank_closing), 32'h20);
      check(32'(bank_open), 32'h81);
      idle(1);
      issue(CMD_PRE, 3'h1, 14'h0400);
      idle(2);
      check(32'(bank_open), 32'h00);
      idle(4);
    end
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_fail++;
    report_and_stop();
  end
endmodule
